// *** hw/adc_seq_defs.svh ***
// constants for the converter sequencer control block
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define FRAME_BITS        5'h10
`define CTRL_WRITE_POS    15
`define CTRL_SEQ_POS      14
`define CTRL_ADDR_HI      13
`define CTRL_ADDR_LO      10
`define CTRL_PM_HI        9
`define CTRL_PM_LO        8
`define CTRL_MASKSEL_POS  7
`define CTRL_RESET        11'h000
`define MASK_RESET        16'h0000
`define MUX_SWITCH_EDGE   5'h0E
`define WAKE_TIME_NS      1000
`define CLK_PERIOD_NS     20
`define WAKE_CYCLES       ((`WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** hw/adc_seq_pkg.sv ***
// types shared by the converter sequencer control block
package adc_seq_pkg;
    typedef enum logic [1:0]
    {
        PM_STANDBY  = 2'h0,
        PM_AUTO_OFF = 2'h1,
        PM_SHUTDOWN = 2'h2,
        PM_NORMAL   = 2'h3
    } power_mode_t;

    typedef struct packed
    {
        logic              sequence_control_bit;
        logic [3:0]        channel_address_field;
        power_mode_t       power_mode;
        logic              mask_select;
        logic              weak_drive;
        logic              range_sel;
        logic              coding_sel;
    } ctrl_t;

    typedef enum logic [2:0]
    {
        SQ_SINGLE = 3'h1,
        SQ_MASK   = 3'h2,
        SQ_CONSEC = 3'h4
    } seq_state_t;
endpackage : adc_seq_pkg

// *** hw/adc_link_sampler.sv ***
// synchroniser and edge finder for the serial link pins
`timescale 1ns/1ps
module adc_link_sampler
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // raw pins
    input  wire logic sclk_pin,
    input  wire logic fs_pin,
    input  wire logic din_pin,
    // sampled outputs
    output logic      sclk_fall,
    output logic      fs_fall,
    output logic      fs_level,
    output logic      din
);
    logic [1:0] sclk_sync;
    logic [1:0] fs_sync;
    logic [1:0] din_sync;
    logic       sclk_prev;
    logic       fs_prev;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_sync <= 2'h3;
            fs_sync   <= 2'h3;
            din_sync  <= 2'h0;
            sclk_prev <= 1'h1;
            fs_prev   <= 1'h1;
        end
        else
        begin
            sclk_sync <= {sclk_sync[0], sclk_pin};
            fs_sync   <= {fs_sync[0], fs_pin};
            din_sync  <= {din_sync[0], din_pin};
            sclk_prev <= sclk_sync[1];
            fs_prev   <= fs_sync[1];
        end
    end

    assign sclk_fall = sclk_prev & ~sclk_sync[1];
    assign fs_fall   = fs_prev & ~fs_sync[1];
    assign fs_level  = fs_sync[1];
    assign din       = din_sync[1];
endmodule : adc_link_sampler

// *** hw/adc_frame_shifter.sv ***
// serial-in shift register that gathers one 16-bit frame
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_frame_shifter
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // sampled link
    input  wire logic        fs_fall,
    input  wire logic        fs_level,
    input  wire logic        sclk_fall,
    input  wire logic        din,
    // frame out
    output logic [15:0]      frame,
    output logic [4:0]       edge_count,
    output logic             frame_done
);
    logic [15:0] shift;
    logic        active;
    wire         take_bit = active & ~fs_level & sclk_fall;
    wire         last_bit = take_bit & (edge_count == `FRAME_BITS - 5'h01);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift      <= 16'h0000;
            frame      <= 16'h0000;
            edge_count <= 5'h00;
            active     <= 1'h0;
            frame_done <= 1'h0;
        end
        else
        begin
            frame_done <= last_bit;
            if (fs_fall)
            begin
                active     <= 1'h1;
                edge_count <= 5'h00;
            end
            else if (take_bit)
            begin
                // msb first
                shift      <= {shift[14:0], din};
                edge_count <= edge_count + 5'h01;
                if (last_bit)
                begin
                    frame  <= {shift[14:0], din};
                    active <= 1'h0;
                end
            end
        end
    end
endmodule : adc_frame_shifter

// *** hw/adc_seq_ctrl.sv ***
// converter channel sequencer and control register
//
// Operation
// - the 4-bit channel address selects the input with that binary index
// - power field picks normal, shutdown, autoshutdown or autostandby
// - full shutdown keeps control contents until power field rewritten
// - autoshutdown powers off after each conversion; host waits wake time
// - autostandby keeps bias on and wakes within one dummy cycle
// - both sequence bits zero: each conversion uses the last written address
// - sequence 0 with mask select 1 makes next write load the mask
// - sequence 1 mask select 0 updates fields without stopping a sequence
// - both bits set: convert channels 0 up to address field, repeat
// - the 16-bit channel mask is write-only, never read back
// - mask shifts in msb first over 16 falling serial clock edges
// - mask captured only when prior control write chose mask loading
// - each mask bit enables one channel; enabled channels may be sparse
// - step enabled channels ascending per frame sync; stop on any write but sequence 1 mask select 0
// - control register updates only when the leading write bit is one
// - input mux switches on the fourteenth falling serial clock edge
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_seq_ctrl
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // serial link from the host
    input  wire logic        converter_serial_clock,
    input  wire logic        converter_frame_sync,
    input  wire logic        converter_serial_in,
    // converter control outputs
    output logic [3:0]       mux_channel,
    output logic [15:0]      channel_select,
    output logic             converter_powered,
    output logic             bias_powered,
    output logic             converter_ready,
    output logic             range_sel,
    output logic             coding_sel,
    output logic             weak_drive,
    output logic             mask_loaded
);
    logic [1:0]  rst_sync;
    wire         rst_n = rst_sync[1];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'h1};
    end

    default clocking check_clk @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic        sclk_fall;
    logic        fs_fall;
    logic        fs_level;
    logic        din;
    logic [15:0] frame;
    logic [4:0]  edge_count;
    logic        frame_done;

    adc_link_sampler u_sampler
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .sclk_pin  (converter_serial_clock),
        .fs_pin    (converter_frame_sync),
        .din_pin   (converter_serial_in),
        .sclk_fall (sclk_fall),
        .fs_fall   (fs_fall),
        .fs_level  (fs_level),
        .din       (din)
    );

    adc_frame_shifter u_shifter
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .fs_fall    (fs_fall),
        .fs_level   (fs_level),
        .sclk_fall  (sclk_fall),
        .din        (din),
        .frame      (frame),
        .edge_count (edge_count),
        .frame_done (frame_done)
    );

    // next channel above cur in mask, wrapping; holds cur when mask empty
    function automatic logic [3:0] next_in_mask(input logic [15:0] m,
                                                 input logic [3:0]  cur);
        logic [3:0] c;
        logic       found;
        next_in_mask = cur;
        found = 1'h0;
        for (int i = 1; i <= 16; i++)
        begin
            c = 4'(cur + i[3:0]);
            if (!found && m[c])
            begin
                next_in_mask = c;
                found = 1'h1;
            end
        end
    endfunction : next_in_mask

    adc_seq_pkg::ctrl_t      ctrl;
    adc_seq_pkg::seq_state_t state;
    logic [15:0]             channel_sequence_mask;  // no read path
    logic                    mask_pending;
    logic [3:0]              next_channel;
    logic                    conv_active;
    logic [5:0]              wake_count;

    wire adc_seq_pkg::ctrl_t frame_ctrl = adc_seq_pkg::ctrl_t'(frame[14:4]);
    wire write_bit   = frame[`CTRL_WRITE_POS];
    wire is_mask_fr  = frame_done & mask_pending;
    wire is_ctrl_wr  = frame_done & ~mask_pending & write_bit;
    wire new_seq     = frame_ctrl.sequence_control_bit;
    wire new_msel    = frame_ctrl.mask_select;
    wire keep_seq    = new_seq & ~new_msel;
    wire mux_switch  = sclk_fall & ~fs_level
                       & (edge_count == `MUX_SWITCH_EDGE - 5'h01);
    wire [3:0] consec_next   =
        (next_channel >= ctrl.channel_address_field) ? 4'h0
                                                      : next_channel + 4'h1;

    // control register and mask capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl                  <= adc_seq_pkg::ctrl_t'(`CTRL_RESET);
            channel_sequence_mask <= `MASK_RESET;
            mask_pending          <= 1'h0;
        end
        else if (is_mask_fr)
        begin
            channel_sequence_mask <= frame;
            mask_pending          <= 1'h0;
        end
        else if (is_ctrl_wr)
        begin
            ctrl         <= frame_ctrl;
            mask_pending <= ~new_seq & new_msel;
        end
    end

    // sequencer state and next channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state        <= adc_seq_pkg::SQ_SINGLE;
            next_channel <= 4'h0;
        end
        else if (is_mask_fr)
        begin
            state        <= adc_seq_pkg::SQ_MASK;
            // parked on 15 so the next frame sync lands on the lowest
            // enabled channel; an empty mask keeps the old channel
            next_channel <= (frame == 16'h0000) ? next_channel : 4'hF;
        end
        else if (is_ctrl_wr && !keep_seq)
        begin
            case ({new_seq, new_msel})
                2'h3:
                begin
                    state        <= adc_seq_pkg::SQ_CONSEC;
                    // parked on the last channel so the first step wraps to 0
                    next_channel <= frame_ctrl.channel_address_field;
                end
                default:
                begin
                    state        <= adc_seq_pkg::SQ_SINGLE;
                    next_channel <= frame_ctrl.channel_address_field;
                end
            endcase
        end
        else if (fs_fall)
        begin
            case (state)
                adc_seq_pkg::SQ_MASK:
                    next_channel <= next_in_mask(channel_sequence_mask,
                                                 next_channel);
                adc_seq_pkg::SQ_CONSEC:
                    next_channel <= consec_next;
                adc_seq_pkg::SQ_SINGLE:
                    next_channel <= next_channel;
                default:
                    state <= adc_seq_pkg::SQ_SINGLE;
            endcase
        end
    end

    // mux follows the pending channel on the fourteenth falling edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mux_channel <= 4'h0;
        else if (mux_switch)
            mux_channel <= next_channel;
    end

    // power sequencing: conversion runs from frame sync to frame end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conv_active <= 1'h0;
            wake_count  <= 6'h00;
        end
        else
        begin
            if (fs_fall)
                conv_active <= 1'h1;
            else if (frame_done)
                conv_active <= 1'h0;
            if (!converter_powered)
                wake_count <= 6'h00;
            else if (wake_count != 6'(`WAKE_CYCLES))
                wake_count <= wake_count + 6'h01;
        end
    end

    wire pm_normal  = ctrl.power_mode == adc_seq_pkg::PM_NORMAL;
    wire pm_off     = ctrl.power_mode == adc_seq_pkg::PM_SHUTDOWN;
    wire pm_standby = ctrl.power_mode == adc_seq_pkg::PM_STANDBY;

    assign converter_powered = pm_normal | (!pm_off & conv_active);
    assign bias_powered      = !pm_off
                               & (converter_powered | pm_standby);
    // normal mode needs no wake-up wait
    assign converter_ready   = pm_normal
                               | (converter_powered
                                  & wake_count == 6'(`WAKE_CYCLES));
    assign channel_select    = 16'h0001 << mux_channel;
    assign range_sel         = ctrl.range_sel;
    assign coding_sel        = ctrl.coding_sel;
    assign weak_drive        = ctrl.weak_drive;
    assign mask_loaded       = state == adc_seq_pkg::SQ_MASK;

    // power-up from a low-power mode
    sequence wake_start;
        $rose(converter_powered) && !pm_normal;
    endsequence

    chk_mask_capture: assert property (
        is_mask_fr |=> channel_sequence_mask == $past(frame))
        else $error("mask not captured");

    chk_mask_only: assert property (
        (frame_done && !mask_pending) |=> $stable(channel_sequence_mask))
        else $error("mask changed without a pending load");

    chk_ctrl_hold: assert property (
        (frame_done && !write_bit && !mask_pending) |=> $stable(ctrl))
        else $error("control changed without write bit");

    chk_shutdown_off: assert property (
        pm_off |-> !converter_powered && !bias_powered)
        else $error("powered in shutdown");

    chk_normal_on: assert property (
        pm_normal |-> converter_powered && converter_ready)
        else $error("normal mode not powered");

    chk_single_addr: assert property (
        (is_ctrl_wr && !new_seq && !new_msel)
        |=> next_channel == $past(frame_ctrl.channel_address_field))
        else $error("single channel not taken from address");

    chk_keep_seq: assert property (
        (is_ctrl_wr && keep_seq) |=> state == $past(state))
        else $error("sequence interrupted");

    chk_consec_wrap: assert property (
        (state == adc_seq_pkg::SQ_CONSEC && fs_fall && !frame_done
         && next_channel >= ctrl.channel_address_field)
        |=> next_channel == 4'h0)
        else $error("consecutive sequence did not wrap");

    chk_consec_bound: assert property (
        (state == adc_seq_pkg::SQ_CONSEC && mux_switch)
        |=> mux_channel <= ctrl.channel_address_field)
        else $error("consecutive channel beyond final channel");

    chk_mask_enabled: assert property (
        (state == adc_seq_pkg::SQ_MASK && mux_switch
         && channel_sequence_mask != 16'h0000)
        |=> channel_sequence_mask[mux_channel])
        else $error("mux on a channel outside the mask");

    chk_mux_edge: assert property (
        mux_switch |=> mux_channel == $past(next_channel))
        else $error("mux not switched");

    chk_mux_hold: assert property (
        !mux_switch |=> $stable(mux_channel))
        else $error("mux moved off its switching edge");

    chk_empty_hold: assert property (
        (state == adc_seq_pkg::SQ_MASK && fs_fall && !frame_done
         && channel_sequence_mask == 16'h0000) |=> $stable(next_channel))
        else $error("empty mask moved channel");

    chk_wake_time: assert property (
        wake_start |-> !converter_ready[*8])
        else $error("ready before wake time");
endmodule : adc_seq_ctrl

// *** verification/host_serial_model.sv ***
// host serial port model driving the converter link
`timescale 1ns/1ps
module host_serial_model
(
    // serial link to the converter
    output logic sclk,
    output logic fs_n,
    output logic sdi
);
    initial
    begin
        sclk = 1'h1;
        fs_n = 1'h1;
        sdi  = 1'h0;
    end

    // serial clock stands high outside frames
    task automatic send_frame(input logic [15:0] word);
        fs_n = 1'h0;
        for (int i = 15; i >= 0; i--)
        begin
            sdi = word[i];
            #80 sclk = 1'h0;
            #80 sclk = 1'h1;
        end
        #80 fs_n = 1'h1;
        // released line must not keep the last bit
        sdi = ~word[0];
    endtask : send_frame
endmodule : host_serial_model

// *** verification/adc_seq_ctrl_bench.sv ***
// self-checking bench for the converter sequencer control
`timescale 1ns/1ps
module adc_seq_ctrl_bench;
    logic        clk;
    logic        rstn;
    logic        sclk;
    logic        fs_n;
    logic        sdi;
    logic [3:0]  mux_channel;
    logic [15:0] channel_select;
    logic        converter_powered;
    logic        bias_powered;
    logic        converter_ready;
    logic        range_sel;
    logic        coding_sel;
    logic        weak_drive;
    logic        mask_loaded;
    int          errors;
    int          total_checks;
    // per power mode: idle, 900 ns into a frame, 1200 ns into it
    logic [2:0]  pwr [4]      = '{3'h4, 3'h0, 3'h0, 3'h7};
    logic [2:0]  pwr_mid [4]  = '{3'h2, 3'h2, 3'h0, 3'h3};
    logic [2:0]  pwr_late [4] = '{3'h7, 3'h7, 3'h0, 3'h7};

    adc_seq_ctrl adc_seq_ctrl_i
    (
        .clk                    (clk),
        .rstn                   (rstn),
        .converter_serial_clock (sclk),
        .converter_frame_sync   (fs_n),
        .converter_serial_in    (sdi),
        .mux_channel            (mux_channel),
        .channel_select         (channel_select),
        .converter_powered      (converter_powered),
        .bias_powered           (bias_powered),
        .converter_ready        (converter_ready),
        .range_sel              (range_sel),
        .coding_sel             (coding_sel),
        .weak_drive             (weak_drive),
        .mask_loaded            (mask_loaded)
    );

    host_serial_model host_serial_model_i
    (
        .sclk (sclk),
        .fs_n (fs_n),
        .sdi  (sdi)
    );

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic end_sim;
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [15:0] ctrl(input logic seq,
        input logic [3:0] addr, input logic [1:0] pm, input logic msel,
        input logic [2:0] wrc);
        return {1'h1, seq, addr, pm, msel, wrc, 4'h0};
    endfunction : ctrl

    // next enabled channel above c, wrapping
    function automatic logic [3:0] next_en(input logic [15:0] m,
        input logic [3:0] c);
        logic [3:0] n;
        n = c;
        for (int k = 0; k < 16; k++)
        begin
            n = n + 4'h1;
            if (m[n])
                return n;
        end
        return c;
    endfunction : next_en

    // link edges fall on clk negedges, away from the sampling edge
    task automatic wr(input logic [15:0] w);
        @(negedge clk);
        host_serial_model_i.send_frame(w);
        repeat (10) @(negedge clk);
    endtask : wr

    // idle frames only: the sequence must advance by itself
    task automatic seq_check(input logic [15:0] m, input int n,
        input logic restart);
        logic [3:0] exp;
        exp = restart ? next_en(m, 4'hF) : next_en(m, mux_channel);
        wr(16'h0000);
        check(mux_channel, exp);
        check(m[mux_channel], 1'h1);
        repeat (n)
        begin
            exp = next_en(m, exp);
            wr(16'h0000);
            check(mux_channel, exp);
        end
    endtask : seq_check

    initial
    begin
        #1000000;
        errors++;
        end_sim();
    end

    initial
    begin
        errors = 0;
        total_checks = 0;
        rstn = 1'h0;
        repeat (6) @(negedge clk);
        rstn = 1'h1;
        repeat (4) @(negedge clk);
        check({mask_loaded, weak_drive, range_sel, coding_sel, mux_channel},
              16'h0000);
        check(channel_select, 16'h0001);
        check({bias_powered, converter_powered}, 16'h0002);
        for (int i = 0; i < 16; i++)
        begin
            wr(ctrl(1'h0, i[3:0], 2'h3, 1'h0, 3'h0));
            wr(16'h0000);
            check(mux_channel, i[3:0]);
            check(channel_select, 16'h0001 << i);
        end
        // every power mode: standby and autoshutdown wake time must elapse inside the frame
        for (int i = 3; i >= 0; i--)
        begin
            wr(ctrl(1'h0, 4'h2, i[1:0], 1'h0, 3'h0));
            fork
                wr(16'h0000);
                begin
                    @(negedge fs_n);
                    repeat (45) @(negedge clk);
                    check({converter_powered, converter_ready},
                          pwr_mid[i]);
                    repeat (15) @(negedge clk);
                    check({bias_powered, converter_powered,
                           converter_ready}, pwr_late[i]);
                end
            join
            check({bias_powered, converter_powered, converter_ready},
                  pwr[i]);
        end
        wr(ctrl(1'h0, 4'h5, 2'h3, 1'h0, 3'h5));
        wr({1'h0, 1'h1, 4'hA, 2'h0, 1'h1, 3'h2, 4'h0});
        check({mask_loaded, weak_drive, range_sel, coding_sel},
              16'h5);
        check(mux_channel, 4'h5);
        wr(ctrl(1'h0, 4'h0, 2'h3, 1'h1, 3'h0));
        wr(16'h0212);
        check(mask_loaded, 1'h1);
        seq_check(16'h0212, 5, 1'h1);
        wr(ctrl(1'h1, 4'h0, 2'h3, 1'h0, 3'h3));
        check({mask_loaded, range_sel, coding_sel}, 16'h7);
        seq_check(16'h0212, 3, 1'h0);
        wr(ctrl(1'h0, 4'h7, 2'h3, 1'h0, 3'h0));
        wr(16'h0000);
        check({mask_loaded, mux_channel}, 16'h07);
        wr(ctrl(1'h1, 4'h3, 2'h3, 1'h1, 3'h0));
        seq_check(16'h000F, 6, 1'h1);
        wr(ctrl(1'h0, 4'h9, 2'h3, 1'h0, 3'h0));
        wr(16'h0000);
        check(mux_channel, 4'h9);
        wr(ctrl(1'h0, 4'h6, 2'h3, 1'h0, 3'h0));
        wr(ctrl(1'h0, 4'h6, 2'h3, 1'h1, 3'h0));
        wr(16'h0000);
        wr(16'h0000);
        wr(16'h0000);
        check(mux_channel, 4'h6);
        end_sim();
    end
endmodule : adc_seq_ctrl_bench
